// ---- tss_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// measurement engine model
module tss_engine import tss_pkg::*; (
  input  wire logic        clock,       // system clock
  input  wire logic        resetn,      // sync reset, low
  input  wire logic        go,          // run one measurement
  input  wire logic        meas_enable, // store lets us measure
  input  wire logic [15:0] sig_val,     // result to report
  output var tss_meas_in_t meas_in,     // start, done, result
  output logic             busy         // measurement running
);
  logic [1:0]  cnt_q;
  logic [15:0] last_q;
  // start, two idle cycles, then done; the result bus carries the
  // inverse of the last result outside done, so late sampling shows
  always_ff @(posedge clock) begin
    meas_in.start <= resetn && go && meas_enable && !busy;
    meas_in.done  <= resetn && busy && cnt_q == 2'h0;
    meas_in.sig   <= ~last_q;
    if (!resetn) begin
      busy   <= 1'b0;
      cnt_q  <= 2'h0;
      last_q <= 16'h0000;
    end else if (go && meas_enable && !busy) begin
      busy  <= 1'b1;
      cnt_q <= 2'h2;
    end else if (busy && cnt_q == 2'h0) begin
      busy        <= 1'b0;
      last_q      <= sig_val;
      meas_in.sig <= sig_val;
    end else if (busy) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule : tss_engine
`default_nettype wire

// ---- tss_pkg.sv ----
// ==========================================================================
// shared constants and types
package tss_pkg;
  localparam int TSS_SIG_W = 16;
  localparam int TSS_DEPTH = 32;
  localparam int TSS_AW    = 8;

  // register byte offsets
  localparam logic [7:0] TSS_A_CTRL = 8'h00;
  localparam logic [7:0] TSS_A_KEY  = 8'h04;
  localparam logic [7:0] TSS_A_STAT = 8'h08;
  localparam logic [7:0] TSS_A_AGG  = 8'h0C;
  localparam logic [7:0] TSS_A_REF  = 8'h10;

  // key register bits (write-one pulses)
  localparam int TSS_K_PROBE   = 0;
  localparam int TSS_K_REVIEW  = 1;
  localparam int TSS_K_REPLACE = 2;
  localparam int TSS_K_CLEAR   = 3;
  // control register bits
  localparam int TSS_C_HOLD    = 0;
  // status register fields
  localparam int TSS_S_REVIEW  = 0;
  localparam int TSS_S_REPLACE = 1;
  localparam int TSS_S_ERR     = 2;
  localparam int TSS_S_ARMED   = 3;
  localparam int TSS_S_ECODE   = 8;
  localparam int TSS_S_COUNT   = 16;

  localparam logic [7:0]  TSS_ERR_NONE  = 8'h00;
  localparam logic [7:0]  TSS_ERR_EMPTY = 8'h01;
  localparam logic [7:0]  TSS_ERR_AGG   = 8'h02;
  localparam logic [6:0]  TSS_REF_RST   = 7'h00;
  localparam logic [7:0]  TSS_REF_MOD   = 8'h64;
  localparam logic [6:0]  TSS_DEC       = 7'h0A;
  localparam logic [3:0]  TSS_DP_ALL    = 4'hF;
  localparam logic [3:0]  TSS_DP_NONE   = 4'h0;
  localparam logic [15:0] TSS_SIG_RST   = 16'h0000;
  localparam logic [31:0] TSS_WORD_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    TSS_IDLE  = 3'b001,
    TSS_ARMED = 3'b010,
    TSS_TRIG  = 3'b100
  } tss_meas_t;

  typedef struct packed {
    logic                 start;
    logic                 done;
    logic [TSS_SIG_W-1:0] sig;
  } tss_meas_in_t;

  typedef struct packed {
    logic [TSS_SIG_W-1:0] sig;
    logic [7:0]           ref_bcd;
    logic                 ref_on;
    logic [3:0]           dp;
    logic                 agg_led;
  } tss_disp_t;
endpackage : tss_pkg

// ---- tss_store.sv ----
// Function
// - probe press marks next started measurement
// - only triggered results enter the store
// - only triggered results change the aggregate
// - hold mode displays triggered results only
// - 32-deep push-down stack, oldest dropped
// - reference numbers start at 1, keep counting
// - numbering restarts on clear/reset, wraps from 99 to 0
// - reference numbers kept as two digits
// - aggregate updated from previous plus new
// - aggregate is sum of triggered results
// - review opens on aggregate, all points lit
// - review key toggles review mode
// - probe in review steps newest to oldest
// - past oldest wraps to the aggregate
// - review without replace: no measuring
// - replace alone overwrites newest entry
// - replace with review overwrites shown entry
// - aggregate cannot be replaced
// - replacement recomputes the aggregate
// - entries never deleted, only overwritten
// - clear empties store and aggregate, keeps review/replace/hold modes, resets gate
// - under error first clear drops message
// - probe in self-test starts segment test
// - replace on empty store raises error
// - replacing aggregate raises error
// - pending error ignores all but clear
`timescale 1ns/1ns
`default_nettype none
module tss_store import tss_pkg::*; #(
  parameter int DEPTH = TSS_DEPTH             // stack depth
) (
  input  wire logic                 clock,        // 25 MHz clock
  input  wire logic                 resetn,       // sync reset, low
  input  wire logic                 ce,           // clock enable
  input  wire logic                 psel,         // apb select
  input  wire logic                 penable,      // apb enable
  input  wire logic                 pwrite,       // apb direction
  input  wire logic [TSS_AW-1:0]    paddr,        // apb byte address
  input  wire logic [31:0]          pwdata,       // apb write data
  output logic      [31:0]          prdata,       // apb read data
  output logic                      pready,       // apb ready
  output logic                      pslverr,      // apb error
  input  wire logic                 probe_press,  // probe button pulse
  input  wire tss_meas_in_t         meas_in,      // engine result
  input  wire logic                 fail_valid,   // failure report
  input  wire logic [7:0]           fail_code,    // failure number
  input  wire logic                 selftest,     // self-test running
  input  wire logic                 unstable_in,  // engine unstable
  output tss_disp_t                 disp,         // display drive
  output logic                      meas_enable,  // engine may measure
  output logic                      meas_trig,    // current is triggered
  output logic                      gate_reset,   // clear pulse
  output logic      [7:0]           error_code,   // shown message
  output logic                      unstable_led, // unstable lamp
  output logic                      seg_test      // segment test pulse
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT0 = '0;
  localparam logic [AW-1:0] ONE  = AW'(1);

  // ========================================================================
  // helpers
  // two-digit decimal form of a 0..99 count
  function automatic logic [7:0] to_bcd(input logic [6:0] v);
    logic [6:0] t;
    t = v / TSS_DEC;
    return {t[3:0], 4'(v - 7'(t * TSS_DEC))};
  endfunction : to_bcd

  // reference number of the entry k places below the newest
  function automatic logic [6:0] ref_at(input logic [6:0] r,
                                        input logic [AW-1:0] k);
    logic [7:0] s;
    s = {1'b0, r} + TSS_REF_MOD - 8'(k);
    if (s >= TSS_REF_MOD) begin
      s = s - TSS_REF_MOD;
    end
    return s[6:0];
  endfunction : ref_at

  // memory slot of the entry k places below the newest
  function automatic logic [AW-1:0] slot(input logic [AW-1:0] h,
                                         input logic [AW-1:0] k);
    return AW'(h - ONE - k);
  endfunction : slot

  // ========================================================================
  // state
  logic [TSS_SIG_W-1:0] mem [DEPTH];
  logic [AW-1:0]        head_q;
  logic [CW-1:0]        count_q;
  logic [6:0]           ref_q;
  logic [TSS_SIG_W-1:0] agg_q;
  logic [TSS_SIG_W-1:0] last_q;
  logic                 hold_q;
  logic                 review_q;
  logic                 replace_q;
  logic [CW-1:0]        pos_q;
  logic [7:0]           err_q;
  tss_meas_t            state_q;
  logic                 tgt_rep_q;
  logic [AW-1:0]        tgt_k_q;

  // ========================================================================
  // event decode
  logic apb_wr, key_wr, probe_ev, clear_ev, err_pend, live;
  logic full_clear, msg_clear, review_ev, replace_ev, nonmeas;
  logic probe_live, step, rep_try, rep_err_empty, rep_err_agg, arm;
  logic st, st_push, st_rep;

  assign apb_wr     = ce & psel & penable & pready & pwrite;
  assign key_wr     = apb_wr & (paddr == TSS_A_KEY);
  assign probe_ev   = ce & (probe_press | (key_wr & pwdata[TSS_K_PROBE]));
  assign clear_ev   = key_wr & pwdata[TSS_K_CLEAR];
  assign err_pend   = (err_q != TSS_ERR_NONE);
  // anything but clear is dropped while a message stands
  assign live       = ~err_pend & ~selftest;
  assign full_clear = clear_ev & ~err_pend;
  assign msg_clear  = clear_ev & err_pend;
  assign review_ev  = live & key_wr & pwdata[TSS_K_REVIEW];
  assign replace_ev = live & key_wr & pwdata[TSS_K_REPLACE];
  assign nonmeas    = review_q & ~replace_q;
  assign probe_live = live & probe_ev;
  assign step       = probe_live & nonmeas;
  assign rep_try    = probe_live & replace_q;
  assign rep_err_empty = rep_try & (count_q == CNT0);
  assign rep_err_agg   = rep_try & review_q & (pos_q == CNT0)
                         & (count_q != CNT0);
  assign arm        = probe_live & ~nonmeas & ~rep_err_empty
                      & ~rep_err_agg;
  assign st         = ce & (state_q == TSS_TRIG) & meas_in.done
                      & ~full_clear;
  assign st_push    = st & ~tgt_rep_q;
  assign st_rep     = st & tgt_rep_q;

  // ========================================================================
  // triggered-measurement tracker
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q   <= TSS_IDLE;
      tgt_rep_q <= 1'b0;
      tgt_k_q   <= '0;
    end else if (ce) begin
      if (full_clear) begin
        state_q <= TSS_IDLE;
      end else begin
        unique case (state_q)
          TSS_IDLE, TSS_ARMED: begin
            if (state_q == TSS_ARMED && meas_in.start) begin
              state_q <= TSS_TRIG;
            end else if (arm) begin
              state_q   <= TSS_ARMED;
              tgt_rep_q <= replace_q;
              // replace alone hits the newest, with review the shown one
              tgt_k_q   <= review_q ? AW'(pos_q - CW'(1)) : '0;
            end
          end
          TSS_TRIG: begin
            if (meas_in.done) begin
              state_q <= TSS_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ========================================================================
  // stack storage; no reset, emptiness is carried by count_q
  always_ff @(posedge clock) begin
    if (ce && st_push) begin
      mem[head_q] <= meas_in.sig;
    end else if (ce && st_rep) begin
      mem[slot(head_q, tgt_k_q)] <= meas_in.sig;
    end
  end

  // stack pointer and fill level
  always_ff @(posedge clock) begin
    if (!resetn) begin
      head_q  <= '0;
      count_q <= CNT0;
    end else if (ce) begin
      if (full_clear) begin
        head_q  <= '0;
        count_q <= CNT0;
      end else if (st_push) begin
        head_q <= AW'(head_q + ONE);
        if (count_q != FULL) begin
          count_q <= CW'(count_q + CW'(1));
        end
      end
    end
  end

  // reference counter, modulo one hundred
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ref_q <= TSS_REF_RST;
    end else if (ce) begin
      if (full_clear) begin
        ref_q <= TSS_REF_RST;
      end else if (st_push) begin
        ref_q <= (ref_q == 7'(TSS_REF_MOD - 8'h01)) ? TSS_REF_RST
                 : 7'(ref_q + 7'h01);
      end
    end
  end

  // aggregate: wraps at 16 bits, a replace swaps old for new
  always_ff @(posedge clock) begin
    if (!resetn) begin
      agg_q <= TSS_SIG_RST;
    end else if (ce) begin
      if (full_clear) begin
        agg_q <= TSS_SIG_RST;
      end else if (st_push) begin
        agg_q <= agg_q + meas_in.sig;
      end else if (st_rep) begin
        agg_q <= agg_q - mem[slot(head_q, tgt_k_q)]
                 + meas_in.sig;
      end
    end
  end

  // ========================================================================
  // modes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      review_q  <= 1'b0;
      replace_q <= 1'b0;
      pos_q     <= CNT0;
    end else if (ce) begin
      if (review_ev) begin
        review_q <= ~review_q;
        pos_q    <= CNT0;
      end else if (full_clear) begin
        pos_q <= CNT0;
      end else if (step) begin
        // only stored positions are reachable, then back to aggregate
        pos_q <= (pos_q >= count_q) ? CNT0
                 : CW'(pos_q + CW'(1));
      end
      if (replace_ev) begin
        replace_q <= ~replace_q;
      end
    end
  end

  // display-hold setting; ignored in the non-measuring mode
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hold_q <= 1'b0;
    end else if (apb_wr && paddr == TSS_A_CTRL && live && !nonmeas) begin
      hold_q <= pwdata[TSS_C_HOLD];
    end
  end

  // last measured value for the normal display
  always_ff @(posedge clock) begin
    if (!resetn) begin
      last_q <= TSS_SIG_RST;
    end else if (ce) begin
      if (full_clear) begin
        last_q <= TSS_SIG_RST;
      end else if (st || (meas_in.done && !hold_q)) begin
        last_q <= meas_in.sig;
      end
    end
  end

  // error message; a new fault beats the clear of the old one
  always_ff @(posedge clock) begin
    if (!resetn) begin
      err_q <= TSS_ERR_NONE;
    end else if (ce) begin
      if (fail_valid) begin
        err_q <= fail_code;
      end else if (rep_err_empty) begin
        err_q <= TSS_ERR_EMPTY;
      end else if (rep_err_agg) begin
        err_q <= TSS_ERR_AGG;
      end else if (msg_clear) begin
        err_q <= TSS_ERR_NONE;
      end
    end
  end

  // ========================================================================
  // registered outputs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      disp <= '0;
    end else if (ce) begin
      if (review_q && pos_q == CNT0) begin
        disp.sig     <= agg_q;
        disp.ref_bcd <= '0;
        disp.ref_on  <= 1'b0;
        disp.dp      <= TSS_DP_ALL;
        disp.agg_led <= 1'b1;
      end else if (review_q) begin
        disp.sig <= mem[slot(head_q, AW'(pos_q - CW'(1)))];
        disp.ref_bcd <= to_bcd(ref_at(ref_q,
                               AW'(pos_q - CW'(1))));
        disp.ref_on  <= 1'b1;
        disp.dp      <= TSS_DP_NONE;
        disp.agg_led <= 1'b0;
      end else begin
        disp.sig     <= last_q;
        disp.ref_bcd <= '0;
        disp.ref_on  <= 1'b0;
        disp.dp      <= TSS_DP_NONE;
        disp.agg_led <= 1'b0;
      end
    end
  end

  // engine and panel side
  always_ff @(posedge clock) begin
    if (!resetn) begin
      meas_enable  <= 1'b0;
      meas_trig    <= 1'b0;
      gate_reset   <= 1'b0;
      error_code   <= TSS_ERR_NONE;
      unstable_led <= 1'b0;
      seg_test     <= 1'b0;
    end else if (ce) begin
      meas_enable  <= ~nonmeas & ~err_pend & ~full_clear;
      meas_trig    <= (state_q == TSS_TRIG);
      gate_reset   <= full_clear;
      error_code   <= err_q;
      unstable_led <= unstable_in & ~nonmeas & ~full_clear;
      seg_test     <= probe_ev & selftest & ~err_pend;
    end
  end

  // ========================================================================
  // apb slave: one wait-free access phase, ready from the setup cycle
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = TSS_WORD_RST;
    err_d = 1'b0;
    unique case (paddr)
      TSS_A_CTRL: rd_d[TSS_C_HOLD] = hold_q;
      TSS_A_KEY:  rd_d = TSS_WORD_RST;
      TSS_A_STAT: begin
        rd_d[TSS_S_REVIEW]  = review_q;
        rd_d[TSS_S_REPLACE] = replace_q;
        rd_d[TSS_S_ERR]     = err_pend;
        rd_d[TSS_S_ARMED]   = (state_q != TSS_IDLE);
        rd_d[TSS_S_ECODE +: 8]  = err_q;
        rd_d[TSS_S_COUNT +: CW] = count_q;
      end
      TSS_A_AGG:  rd_d[TSS_SIG_W-1:0] = agg_q;
      TSS_A_REF:  rd_d[7:0] = to_bcd(ref_q);
      default:    err_d = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= TSS_WORD_RST;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel & ~penable;
      prdata  <= rd_d;
      pslverr <= psel & ~penable & err_d;
    end
  end

  // ========================================================================
  // checks
  untrig_no_store_a: assert property (@(posedge clock) disable iff (!resetn)
    ce && meas_in.done && state_q != TSS_TRIG && !full_clear
    |=> $stable(head_q))
    else $error("untriggered result moved the stack");

  agg_add_a: assert property (@(posedge clock) disable iff (!resetn)
    st_push |=> agg_q == 16'($past(agg_q) + $past(meas_in.sig)))
    else $error("aggregate not advanced by triggered result");

  hold_display_a: assert property (@(posedge clock) disable iff (!resetn)
    ce && hold_q && !st && !full_clear |=> $stable(last_q))
    else $error("hold mode display changed untriggered");

  stack_bound_a: assert property (@(posedge clock) disable iff (!resetn)
    st_push && count_q == FULL |=> count_q == FULL && ref_q != $past(ref_q))
    else $error("full stack push misbehaved");

  ref_digits_a: assert property (@(posedge clock) disable iff (!resetn)
    st_push |=> ref_q == 7'((8'($past(ref_q)) + 8'h01) % TSS_REF_MOD)
                && ref_q < 7'(TSS_REF_MOD))
    else $error("reference number out of two digits");

  review_open_a: assert property (@(posedge clock) disable iff (!resetn)
    ce && review_ev && !review_q ##1 ce |=> disp.agg_led && disp.dp == TSS_DP_ALL)
    else $error("review did not open on aggregate");

  no_measure_a: assert property (@(posedge clock) disable iff (!resetn)
    ce && nonmeas |=> !meas_enable && !unstable_led)
    else $error("measuring while in review only");

  error_freeze_a: assert property (@(posedge clock) disable iff (!resetn)
    err_pend |=> $stable(review_q) && $stable(replace_q) && $stable(hold_q))
    else $error("key acted during pending error");

  empty_rep_a: assert property (@(posedge clock) disable iff (!resetn)
    rep_err_empty && !fail_valid |=> err_q == TSS_ERR_EMPTY)
    else $error("empty replace error not raised");

  clear_all_a: assert property (@(posedge clock) disable iff (!resetn)
    full_clear |=> count_q == CNT0 && agg_q == TSS_SIG_RST
                   && ref_q == TSS_REF_RST && gate_reset)
    else $error("clear left state behind");

endmodule : tss_store
`default_nettype wire

// ---- tss_store_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench for the triggered signature store
module tss_store_bench import tss_pkg::*; ;
  logic         clock, resetn, ce, psel, penable, pwrite, pready, pslverr;
  logic         probe_press, fail_valid, selftest, unstable_in, go, busy;
  logic         meas_enable, meas_trig, gate_reset, unstable_led, seg_test;
  logic         er, ev;
  logic [7:0]   paddr, fail_code, error_code;
  logic [31:0]  pwdata, prdata, rv, st;
  logic [15:0]  sig_val;
  tss_meas_in_t meas_in;
  tss_disp_t    disp;
  int           mismatches, tests_run, i;
  typedef struct packed {
    logic p; logic [15:0] s; logic [5:0] cnt; logic [15:0] agg; logic [7:0] rf;
  } tss_row_t;
  tss_row_t rows [5] = '{'{1'b0, 16'h1234, 6'h00, 16'h0000, 8'h00},
    '{1'b1, 16'hA001, 6'h01, 16'hA001, 8'h01},
    '{1'b1, 16'h7000, 6'h02, 16'h1001, 8'h02},
    '{1'b0, 16'hFFFF, 6'h02, 16'h1001, 8'h02},
    '{1'b1, 16'hF000, 6'h03, 16'h0001, 8'h03}};
  logic [15:0] sg [5] = '{16'h0F10, 16'hA001, 16'h7000, 16'hF000, 16'h0F0F};

  tss_store DUT (.clock, .resetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .probe_press, .meas_in,
    .fail_valid, .fail_code, .selftest, .unstable_in, .disp, .meas_enable,
    .meas_trig, .gate_reset, .error_code, .unstable_led, .seg_test);
  tss_engine ENG (.clock, .resetn, .go, .meas_enable, .sig_val, .meas_in,
    .busy);

  // ==========================================
  // clock, pulse catcher and watchdog
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // clear and self-test pulses last one cycle, so latch them
  // caught on the pulse itself, so a check on the next edge already sees it
  always @(posedge gate_reset or posedge seg_test) ev <= 1'b1;
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    complete_run();
  end

  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // apb transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    // outputs registered from the write land one edge after it
    repeat (2) @(posedge clock);
  endtask : apb
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv & m, e);
  endtask : rdm
  task automatic key(input int b);
    apb(1'b1, TSS_A_KEY, 32'h0000_0001 << b);
  endtask : key
  task automatic press();
    probe_press <= 1'b1;
    @(posedge clock);
    probe_press <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : press
  // optional trigger, then one engine run; waits for the result to land
  task automatic meas(input logic p, input logic [15:0] s);
    if (p) press();
    {go, sig_val} <= {1'b1, s};
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
    end while (busy === 1'b1);
    repeat (3) @(posedge clock);
  endtask : meas
  task automatic tend(input string s);
    $display("test done: %s", s);
  endtask : tend
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ==========================================
  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, probe_press, fail_valid, selftest} = '0;
    {unstable_in, go, ev} = '0;
    {paddr, fail_code, pwdata, sig_val} = '0;
    ce = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rdm(TSS_A_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_0000);
    // table rows: untriggered results never reach store or aggregate
    for (i = 0; i < 5; i++) begin
      meas(rows[i].p, rows[i].s);
      rdm(TSS_A_STAT, 32'hFFFF_FFFF, {10'h0, rows[i].cnt, 16'h0});
      rdm(TSS_A_AGG, 32'hFFFF_FFFF, {16'h0, rows[i].agg});
      rdm(TSS_A_REF, 32'hFFFF_FFFF, {24'h0, rows[i].rf});
      chk(32'(disp.sig), 32'(rows[i].s));
    end
    tend("rows");
    apb(1'b1, TSS_A_CTRL, 32'h0000_0001);
    meas(1'b0, 16'h5555);
    chk(32'(disp.sig), 32'h0000_F000);
    meas(1'b1, 16'h0F0F);
    chk(32'(disp.sig), 32'h0000_0F0F);
    apb(1'b1, TSS_A_CTRL, 32'h0000_0000);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_0F10);
    tend("hold");
    unstable_in <= 1'b1;
    key(TSS_K_REVIEW);
    chk(32'({disp.agg_led, disp.dp, disp.sig}), 32'({1'b1, TSS_DP_ALL, sg[0]}));
    chk(32'(meas_enable), 32'h0000_0000);
    chk(32'(unstable_led), 32'h0000_0000);
    meas(1'b0, 16'h3333);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_0F10);
    for (i = 4; i >= 0; i--) begin
      press();
      if (i > 0) chk(32'({disp.ref_on, disp.ref_bcd, disp.sig}), 32'({1'b1, 8'(i), sg[i]}));
      else chk(32'({disp.agg_led, disp.sig}), 32'({1'b1, sg[0]}));
    end
    repeat (3) press();
    key(TSS_K_REPLACE);
    chk(32'(unstable_led), 32'h0000_0001);
    unstable_in <= 1'b0;
    meas(1'b1, 16'h0100);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_A010);
    rdm(TSS_A_REF, 32'hFFFF_FFFF, 32'h0000_0004);
    rdm(TSS_A_STAT, 32'h003F_0000, 32'h0004_0000);
    key(TSS_K_REVIEW);
    chk(32'(meas_enable), 32'h0000_0001);
    meas(1'b1, 16'h0001);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_9102);
    rdm(TSS_A_STAT, 32'h003F_0000, 32'h0004_0000);
    tend("review and replace");
    key(TSS_K_REVIEW);
    press();
    chk(32'(error_code), 32'(TSS_ERR_AGG));
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_9102);
    key(TSS_K_REVIEW);
    rdm(TSS_A_STAT, 32'h0000_0001, 32'h0000_0001);
    key(TSS_K_CLEAR);
    chk(32'(error_code), 32'h0000_0000);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_9102);
    ev <= 1'b0;
    key(TSS_K_CLEAR);
    chk(32'(ev), 32'h0000_0001);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(TSS_A_STAT, 32'h003F_0000, 32'h0000_0000);
    chk(32'(unstable_led), 32'h0000_0000);
    apb(1'b0, TSS_A_STAT, 32'h0000_0000);
    st = rv;
    if (st[0]) key(TSS_K_REVIEW);
    if (!st[1]) key(TSS_K_REPLACE);
    press();
    chk(32'(error_code), 32'(TSS_ERR_EMPTY));
    key(TSS_K_CLEAR);
    key(TSS_K_REPLACE);
    {fail_valid, fail_code} <= {1'b1, 8'h12};
    @(posedge clock);
    fail_valid <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'(error_code), 32'h0000_0012);
    chk(32'(meas_enable), 32'h0000_0000);
    key(TSS_K_REVIEW);
    rdm(TSS_A_STAT, 32'h0000_0001, 32'h0000_0000);
    key(TSS_K_CLEAR);
    chk(32'(error_code), 32'h0000_0000);
    tend("errors and clear");
    for (i = 1; i <= 34; i++) begin
      key(TSS_K_PROBE);
      meas(1'b0, 16'(i));
    end
    rdm(TSS_A_STAT, 32'h003F_0000, 32'h0020_0000);
    rdm(TSS_A_REF, 32'hFFFF_FFFF, 32'h0000_0034);
    key(TSS_K_REVIEW);
    repeat (32) press();
    chk(32'({disp.ref_bcd, disp.sig}), 32'h0003_0003);
    press();
    chk(32'(disp.agg_led), 32'h0000_0001);
    key(TSS_K_REVIEW);
    for (i = 35; i <= 100; i++) begin
      key(TSS_K_PROBE);
      meas(1'b0, 16'(i));
    end
    rdm(TSS_A_REF, 32'hFFFF_FFFF, 32'h0000_0000);
    key(TSS_K_CLEAR);
    meas(1'b1, 16'hBEEF);
    rdm(TSS_A_REF, 32'hFFFF_FFFF, 32'h0000_0001);
    rdm(TSS_A_AGG, 32'hFFFF_FFFF, 32'h0000_BEEF);
    tend("fill and numbering");
    selftest <= 1'b1;
    ev <= 1'b0;
    press();
    chk(32'(ev), 32'h0000_0001);
    selftest <= 1'b0;
    apb(1'b0, 8'hF0, 32'h0000_0000);
    chk({er, rv[30:0]}, 32'h8000_0000);
    tend("self-test and unmapped");
    complete_run();
  end
endmodule : tss_store_bench
`default_nettype wire
